// ==== include/flash_result_pkg.sv ====
package flash_result_pkg;

   // ****************************************
   // Operations issued by user logic
   // ****************************************
   typedef enum logic [2:0] {
      OP_NONE,
      OP_READ,
      OP_SID,
      OP_RDID,
      OP_STATUS,
      OP_ERASE,
      OP_WRITE,
      OP_PROTECT
   } op_t;

   // ****************************************
   // Widths, field positions, reset values
   // ****************************************
   localparam int ADDR_W = 24;
   localparam int BYTE_W = 8;
   localparam int PROT_LSB = 2; // Block protect field in status byte
   localparam int PROT_W = 3;
   localparam int SECT_LSB = 16; // Sector number in address
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [23:0] ADDR_RST = 24'h000000;
   localparam logic [23:0] ADDR_STEP = 24'h000001;

   // Sector protected when its number falls in the top protected span
   function automatic logic is_protected(input logic [23:0] addr, input logic [7:0] stat);
      logic [2:0] bp;
      logic [7:0] mask;
      bp = stat[PROT_LSB +: PROT_W];
      mask = 8'(8'hff << (bp - 3'h1));
      is_protected = (bp != 3'h0) && ((addr[SECT_LSB +: 8] & mask) == mask);
   endfunction

endpackage

// ==== include/flash_result_if.sv ====
`timescale 1ns/10ps
interface flash_result_if;
   import flash_result_pkg::*;

   // Command side, driven by user logic
   logic read;
   logic rden;
   logic read_sid;
   logic read_rdid;
   logic read_status;
   logic sector_erase;
   logic write;
   logic sector_protect;
   logic [23:0] addr;
   logic [7:0] datain;
   logic data_ready;
   // Result side, driven by the controller
   logic busy;
   logic data_valid;
   logic [7:0] dataout;
   logic [23:0] read_address;
   logic [7:0] silicon_ident_out;
   logic [7:0] capacity_id_out;
   logic [7:0] status_out;
   logic erase_refused;
   logic write_refused;

   modport ctrl (
      input read, rden, read_sid, read_rdid, read_status, sector_erase, write,
      input sector_protect, addr, datain, data_ready,
      output busy, data_valid, dataout, read_address, silicon_ident_out,
      output capacity_id_out, status_out, erase_refused, write_refused
   );

   modport user (
      output read, rden, read_sid, read_rdid, read_status, sector_erase, write,
      output sector_protect, addr, datain, data_ready,
      input busy, data_valid, dataout, read_address, silicon_ident_out,
      input capacity_id_out, status_out, erase_refused, write_refused
   );

endinterface // flash_result_if

// ==== design/flash_ctrl_end.sv ====
`timescale 1ns/10ps

// Operation
// [RULE_01] Busy high while executing accepted instruction
// [RULE_02] Busy low once instruction completes
// [RULE_03] Byte strobe marks valid read byte
// [RULE_04] Read byte held until reset or replaced
// [RULE_05] Silicon identification held after its read
// [RULE_06] Erase of protected sector aborted, flagged
// [RULE_07] Write of protected sector aborted, flagged
// [RULE_08] Refusal flag two cycles around busy fall
// [RULE_09] Capacity code held after its read
// [RULE_10] Address of current read byte output
// [RULE_11] Status held until next status read
// [RULE_12] User reads status, samples after busy
// [RULE_13] User holds read permit during reads
// [RULE_14] Status command fetches flash status register
// [RULE_15] Outputs low after reset until accepted
module flash_ctrl_end
   import flash_result_pkg::*;
(
   input wire logic CORE_CLK, // Core clock, 20 MHz
   input wire logic SYS_RST, // Synchronous reset, active high
   flash_result_if.ctrl U, // User logic side
   output logic FL_START, // One-cycle start toward flash engine
   output op_t FL_OP, // Operation for flash engine
   output logic [23:0] FL_ADDR, // Flash address
   output logic [7:0] FL_WDATA, // Byte to write or protect value
   output logic FL_STOP, // Read permit withdrawn, end read
   input wire logic FL_RVALID, // Byte from flash valid
   input wire logic [7:0] FL_RDATA, // Byte from flash
   output logic FL_RREADY, // Controller can take a byte
   input wire logic FL_DONE // Flash engine finished, one cycle
);

   typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_REFUSE, ST_TAIL} state_t;

   state_t state;
   state_t next_state;
   op_t cur_op;
   op_t req_op;
   logic refused_erase;
   logic flash_done;
   logic [23:0] rd_addr;
   logic [7:0] prot_bits;
   logic head_v;
   logic spare_v;
   logic [7:0] spare_data;
   logic [23:0] spare_addr;
   logic push;
   logic pop;
   logic [7:0] sid;
   logic [7:0] cap;
   logic [7:0] stat;

   // ****************************************
   // Command decode and sequencing
   // ****************************************

   // Fixed priority when several strobes arrive together
   always_comb begin
      if (U.read && U.rden) begin
         req_op = OP_READ;
      end else if (U.read_sid) begin
         req_op = OP_SID;
      end else if (U.read_rdid) begin
         req_op = OP_RDID;
      end else if (U.read_status) begin
         req_op = OP_STATUS;
      end else if (U.sector_erase) begin
         req_op = OP_ERASE;
      end else if (U.write) begin
         req_op = OP_WRITE;
      end else if (U.sector_protect) begin
         req_op = OP_PROTECT;
      end else begin
         req_op = OP_NONE;
      end
   end

   // Erase and write of protected targets skip the flash entirely
   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (req_op != OP_NONE) begin
               if ((req_op == OP_ERASE || req_op == OP_WRITE)
                   && is_protected(U.addr, prot_bits)) begin
                  next_state = ST_REFUSE; // RULE_06
               end else begin
                  next_state = ST_RUN;
               end
            end
         end
         ST_RUN: begin
            // Done only once the last read byte has left the buffer
            if (flash_done && !head_v && !spare_v) begin
               next_state = ST_IDLE; // RULE_02
            end
         end
         ST_REFUSE: next_state = ST_TAIL;
         default: next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         state <= ST_IDLE; // RULE_15
      end else begin
         state <= next_state;
      end
   end

   // Latch the accepted operation and its target
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         cur_op <= OP_NONE;
         refused_erase <= 1'b0;
         FL_ADDR <= ADDR_RST;
         FL_WDATA <= BYTE_RST;
      end else if (state == ST_IDLE && req_op != OP_NONE) begin
         cur_op <= req_op;
         refused_erase <= (req_op == OP_ERASE);
         FL_ADDR <= U.addr;
         FL_WDATA <= U.datain;
      end
   end

   // Start pulse on entry into the run state
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         FL_START <= 1'b0;
      end else begin
         FL_START <= (state == ST_IDLE) && (next_state == ST_RUN);
      end
   end

   // Done is remembered, the buffer may still be draining
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         flash_done <= 1'b0;
      end else if (state != ST_RUN) begin
         flash_done <= 1'b0;
      end else if (FL_DONE) begin
         flash_done <= 1'b1;
      end
   end

   assign FL_OP = cur_op;
   assign FL_STOP = (state == ST_RUN) && (cur_op == OP_READ) && !U.rden; // RULE_13
   assign U.busy = (state == ST_RUN) || (state == ST_REFUSE); // RULE_01
   // Flag spans the last busy cycle and the first idle one
   assign U.erase_refused = (state == ST_REFUSE || state == ST_TAIL) && refused_erase; // RULE_08
   assign U.write_refused = (state == ST_REFUSE || state == ST_TAIL) && !refused_erase; // RULE_07

   // ****************************************
   // Read byte path, two-entry buffer
   // ****************************************

   // A full buffer stalls the flash so no byte is dropped
   assign FL_RREADY = (state == ST_RUN) && !(cur_op == OP_READ && spare_v);
   assign push = FL_RVALID && FL_RREADY && (cur_op == OP_READ);
   assign pop = head_v && U.data_ready;
   assign U.data_valid = head_v; // RULE_03

   // Head register is the output; it is not cleared on pop
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         head_v <= 1'b0;
         spare_v <= 1'b0;
         U.dataout <= BYTE_RST;
         U.read_address <= ADDR_RST;
         spare_data <= BYTE_RST;
         spare_addr <= ADDR_RST;
      end else begin
         if (push && (!head_v || pop) && !spare_v) begin
            head_v <= 1'b1;
            U.dataout <= FL_RDATA; // RULE_04
            U.read_address <= rd_addr; // RULE_10
         end else if (spare_v && pop) begin
            head_v <= 1'b1;
            U.dataout <= spare_data;
            U.read_address <= spare_addr;
            spare_v <= push;
            spare_data <= FL_RDATA;
            spare_addr <= rd_addr;
         end else if (push) begin
            spare_v <= 1'b1;
            spare_data <= FL_RDATA;
            spare_addr <= rd_addr;
         end else if (pop) begin
            head_v <= 1'b0;
         end
      end
   end

   // Address of the next byte the flash will return
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         rd_addr <= ADDR_RST;
      end else if (state == ST_IDLE && req_op != OP_NONE) begin
         rd_addr <= U.addr;
      end else if (push) begin
         rd_addr <= rd_addr + ADDR_STEP; // RULE_10
      end
   end

   // ****************************************
   // Identification and status capture
   // ****************************************

   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         sid <= BYTE_RST;
         cap <= BYTE_RST;
         stat <= BYTE_RST;
      end else if (FL_RVALID && FL_RREADY) begin
         if (cur_op == OP_SID) begin
            sid <= FL_RDATA; // RULE_05
         end
         if (cur_op == OP_RDID) begin
            cap <= FL_RDATA; // RULE_09
         end
         if (cur_op == OP_STATUS) begin
            stat <= FL_RDATA; // RULE_14
         end
      end
   end

   // Protection follows both status reads and protect writes,
   // while the visible status changes only on a status read
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         prot_bits <= BYTE_RST;
      end else if (FL_RVALID && FL_RREADY && cur_op == OP_STATUS) begin
         prot_bits <= FL_RDATA;
      end else if (state == ST_RUN && FL_DONE && cur_op == OP_PROTECT) begin
         prot_bits <= FL_WDATA;
      end
   end

   assign U.silicon_ident_out = sid;
   assign U.capacity_id_out = cap;
   assign U.status_out = stat; // RULE_11

endmodule // flash_ctrl_end

// ==== design/flash_user_end.sv ====
`timescale 1ns/10ps
module flash_user_end
   import flash_result_pkg::*;
(
   input wire logic CORE_CLK, // Core clock, 20 MHz
   input wire logic SYS_RST, // Synchronous reset, active high
   flash_result_if.user U, // Controller side
   input wire logic REQ_GO, // Start an operation, one cycle
   input wire op_t REQ_OP, // Operation to start
   input wire logic [23:0] REQ_ADDR, // Target address
   input wire logic [7:0] REQ_DATA, // Write byte or protect value
   input wire logic REQ_READ_END, // End a running read, one cycle
   output logic REQ_IDLE, // New operation may start
   output logic REQ_DONE, // Operation finished, one cycle
   output logic BYTE_VALID, // Read byte available
   output logic [7:0] BYTE_DATA, // Read byte
   output logic [23:0] BYTE_ADDR, // Address of read byte
   input wire logic BYTE_READY, // Consumer takes the byte
   output logic [7:0] SID, // Captured silicon identification
   output logic [7:0] CAP, // Captured capacity code
   output logic [7:0] STAT, // Captured status byte
   output logic ERASE_REFUSED, // Last erase was refused
   output logic WRITE_REFUSED // Last write was refused
);

   typedef enum logic [1:0] {U_IDLE, U_ISSUE, U_WAIT} ustate_t;

   ustate_t state;
   op_t op;

   // ****************************************
   // Issue and completion
   // ****************************************

   // Busy rises in the cycle after the strobe, so waiting starts there
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         state <= U_IDLE;
         op <= OP_NONE;
         REQ_DONE <= 1'b0;
      end else begin
         REQ_DONE <= 1'b0;
         case (state)
            U_IDLE: begin
               if (REQ_GO && REQ_OP != OP_NONE) begin
                  state <= U_ISSUE;
                  op <= REQ_OP;
               end
            end
            U_ISSUE: state <= U_WAIT;
            default: begin
               if (!U.busy) begin
                  state <= U_IDLE;
                  REQ_DONE <= 1'b1;
               end
            end
         endcase
      end
   end

   // One-cycle strobes with address and data steady beside them
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         U.addr <= ADDR_RST;
         U.datain <= BYTE_RST;
      end else if (state == U_IDLE && REQ_GO) begin
         U.addr <= REQ_ADDR;
         U.datain <= REQ_DATA;
      end
   end

   assign U.read = (state == U_ISSUE) && (op == OP_READ);
   assign U.read_sid = (state == U_ISSUE) && (op == OP_SID);
   assign U.read_rdid = (state == U_ISSUE) && (op == OP_RDID);
   assign U.read_status = (state == U_ISSUE) && (op == OP_STATUS); // RULE_12
   assign U.sector_erase = (state == U_ISSUE) && (op == OP_ERASE);
   assign U.write = (state == U_ISSUE) && (op == OP_WRITE);
   assign U.sector_protect = (state == U_ISSUE) && (op == OP_PROTECT);
   assign REQ_IDLE = (state == U_IDLE);

   // Permit held from the strobe until the consumer ends the read
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         U.rden <= 1'b0;
      end else if (state == U_IDLE && REQ_GO && REQ_OP == OP_READ) begin
         U.rden <= 1'b1; // RULE_13
      end else if (REQ_READ_END) begin
         U.rden <= 1'b0;
      end
   end

   // ****************************************
   // Results
   // ****************************************

   // Bytes only count while the strobe is high
   assign BYTE_VALID = U.data_valid; // RULE_03
   assign BYTE_DATA = U.dataout;
   assign BYTE_ADDR = U.read_address;
   assign U.data_ready = BYTE_READY;

   // Identification and status sampled only once busy has fallen
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         SID <= BYTE_RST;
         CAP <= BYTE_RST;
         STAT <= BYTE_RST;
      end else if (state == U_WAIT && !U.busy) begin
         if (op == OP_SID) begin
            SID <= U.silicon_ident_out; // RULE_05
         end
         if (op == OP_RDID) begin
            CAP <= U.capacity_id_out; // RULE_09
         end
         if (op == OP_STATUS) begin
            STAT <= U.status_out; // RULE_12
         end
      end
   end

   // Refusal seen during the wait sticks until the next operation
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         ERASE_REFUSED <= 1'b0;
         WRITE_REFUSED <= 1'b0;
      end else if (state == U_IDLE && REQ_GO) begin
         ERASE_REFUSED <= 1'b0;
         WRITE_REFUSED <= 1'b0;
      end else if (state == U_WAIT) begin
         ERASE_REFUSED <= ERASE_REFUSED | U.erase_refused;
         WRITE_REFUSED <= WRITE_REFUSED | U.write_refused;
      end
   end

endmodule // flash_user_end

// ==== verification/flash_result_chk.sv ====
`timescale 1ns/10ps
module flash_result_chk (
   input logic CORE_CLK, // Core clock
   input logic SYS_RST, // Sync reset
   input logic read, // Read strobe
   input logic rden, // Read permit
   input logic read_sid, // Ident strobe
   input logic read_rdid, // Capacity strobe
   input logic read_status, // Status strobe
   input logic sector_erase, // Erase strobe
   input logic write, // Write strobe
   input logic sector_protect, // Protect strobe
   input logic busy, // Operation running
   input logic data_valid, // Byte valid
   input logic data_ready, // Byte taken
   input logic [7:0] dataout, // Read byte
   input logic [23:0] read_address, // Byte address
   input logic [7:0] silicon_ident_out, // Ident
   input logic [7:0] capacity_id_out, // Capacity
   input logic [7:0] status_out, // Status
   input logic erase_refused, // Erase refused
   input logic write_refused // Write refused
);
   // ****************************************
   // Properties
   // ****************************************
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (SYS_RST);
   logic go;
   // Any strobe the controller may take
   assign go = read_sid | read_rdid | read_status | sector_erase | write | sector_protect
      | (read & rden);

   property p_busy_rise;
      go && !busy && !$past(busy) |=> busy;
   endproperty
   a_busy_rise: assert property (p_busy_rise) else $error("busy not raised");
   // Bound fits the short reads of the bench
   property p_busy_end;
      busy |-> ##[0:400] !busy;
   endproperty
   a_busy_end: assert property (p_busy_end) else $error("busy stuck");
   property p_erase_flag;
      $rose(erase_refused) |-> $past(sector_erase) && busy ##1 erase_refused && !busy
         ##1 !erase_refused;
   endproperty
   a_erase_flag: assert property (p_erase_flag) else $error("erase flag shape");
   property p_write_flag;
      $rose(write_refused) |-> $past(write) && busy ##1 write_refused && !busy
         ##1 !write_refused;
   endproperty
   a_write_flag: assert property (p_write_flag) else $error("write flag shape");
   property p_stall;
      data_valid && !data_ready |=> data_valid && $stable(dataout) && $stable(read_address);
   endproperty
   a_stall: assert property (p_stall) else $error("byte lost in stall");
   property p_hold_byte;
      $changed(dataout) |-> data_valid;
   endproperty
   a_hold_byte: assert property (p_hold_byte) else $error("byte changed");
   property p_sid;
      $changed(silicon_ident_out) |-> busy;
   endproperty
   a_sid: assert property (p_sid) else $error("ident changed idle");
   property p_cap;
      $changed(capacity_id_out) |-> busy;
   endproperty
   a_cap: assert property (p_cap) else $error("capacity changed idle");
   property p_stat;
      $changed(status_out) |-> busy;
   endproperty
   a_stat: assert property (p_stat) else $error("status changed idle");
   property p_addr_step;
      data_valid && data_ready ##1 data_valid |-> read_address == $past(read_address) + 24'h000001;
   endproperty
   a_addr_step: assert property (p_addr_step) else $error("address step");
   property p_rst;
      disable iff (1'b0) SYS_RST |=> !busy && !data_valid && !erase_refused && !write_refused;
   endproperty
   a_rst: assert property (p_rst) else $error("outputs after reset");
   // Main scenarios reached
   c_erase: cover property ($rose(erase_refused));
   c_write: cover property ($rose(write_refused));
   c_stall: cover property (data_valid && !data_ready ##1 data_valid && !data_ready);
   c_burst: cover property (data_valid && data_ready ##1 data_valid && data_ready);
endmodule // flash_result_chk

// ==== verification/tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
   import flash_result_pkg::*;
   localparam logic [7:0] SID_VAL = 8'h3c; // Arbitrary identity value
   localparam logic [7:0] CAP_VAL = 8'h17; // Arbitrary capacity code
   logic CORE_CLK = 1'b0, SYS_RST = 1'b1, req_go = 1'b0, req_read_end = 1'b0;
   logic byte_ready = 1'b0, fl_rvalid = 1'b0, fl_done = 1'b0, stall = 1'b0;
   logic fl_start, fl_stop, fl_rready, req_idle, req_done, byte_valid, erase_ref, write_ref;
   op_t fl_op, req_op = OP_NONE;
   logic [23:0] fl_addr, byte_addr, exp_addr, req_addr = 24'h000000;
   logic [7:0] fl_wdata, byte_data, sid, cap, stat, fl_rdata = 8'h00;
   logic [7:0] req_data = 8'h00, stat_reg = 8'h00;
   logic [31:0] rnd = 32'h00016f45;
   int num_errors = 0, checks = 0, cycles = 0, nbytes = 0, want = 0;

   flash_result_if fif();
   flash_ctrl_end flash_ctrl_end_inst (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .U(fif),
      .FL_START(fl_start), .FL_OP(fl_op), .FL_ADDR(fl_addr), .FL_WDATA(fl_wdata),
      .FL_STOP(fl_stop), .FL_RVALID(fl_rvalid), .FL_RDATA(fl_rdata), .FL_RREADY(fl_rready),
      .FL_DONE(fl_done));
   flash_user_end flash_user_end_inst (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .U(fif),
      .REQ_GO(req_go), .REQ_OP(req_op), .REQ_ADDR(req_addr), .REQ_DATA(req_data),
      .REQ_READ_END(req_read_end), .REQ_IDLE(req_idle), .REQ_DONE(req_done),
      .BYTE_VALID(byte_valid), .BYTE_DATA(byte_data), .BYTE_ADDR(byte_addr),
      .BYTE_READY(byte_ready), .SID(sid), .CAP(cap), .STAT(stat),
      .ERASE_REFUSED(erase_ref), .WRITE_REFUSED(write_ref));
   flash_result_chk flash_result_chk_inst (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST),
      .read(fif.read), .rden(fif.rden), .read_sid(fif.read_sid), .read_rdid(fif.read_rdid),
      .read_status(fif.read_status), .sector_erase(fif.sector_erase), .write(fif.write),
      .sector_protect(fif.sector_protect), .busy(fif.busy), .data_valid(fif.data_valid),
      .data_ready(fif.data_ready), .dataout(fif.dataout), .read_address(fif.read_address),
      .silicon_ident_out(fif.silicon_ident_out), .capacity_id_out(fif.capacity_id_out),
      .status_out(fif.status_out), .erase_refused(fif.erase_refused),
      .write_refused(fif.write_refused));

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Flash contents follow from the address alone
   function automatic logic [7:0] fbyte(input logic [23:0] a);
      fbyte = a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'ha5;
   endfunction
   // Protected span is the top 2**(bp-1) sectors, worked out as a range
   function automatic logic exp_prot(input logic [23:0] a, input logic [2:0] bp);
      exp_prot = (bp != 3'h0) && (int'(a[23:16]) >= 256 - (1 << (int'(bp) - 1)));
   endfunction
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("errors=%0d checks=%0d", num_errors, checks);
      if (num_errors == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic reset_dut();
      SYS_RST = 1'b1;
      repeat (10) @(posedge CORE_CLK);
      #2 SYS_RST = 1'b0;
   endtask
   // Tasks start and end 2 ns after a rising edge
   task automatic do_op(input op_t op, input logic [23:0] a, input logic [7:0] d);
      for (int i = 0; i < 500 && req_idle !== 1'b1; i++) begin
         @(posedge CORE_CLK);
         #2;
      end
      req_go = 1'b1;
      req_op = op;
      req_addr = a;
      req_data = d;
      @(posedge CORE_CLK);
      #2 req_go = 1'b0;
      for (int i = 0; i < 900 && req_done !== 1'b1; i++) begin
         @(posedge CORE_CLK);
         #2;
      end
   endtask
   // Read with optional early stall so both buffer entries fill
   task automatic do_read(input logic [23:0] a, input int n, input logic s);
      exp_addr = a;
      nbytes = 0;
      want = n;
      stall = s;
      fork
         do_op(OP_READ, a, 8'h00);
         begin
            repeat (20) @(posedge CORE_CLK);
            #2 stall = 1'b0;
            while (nbytes < want) begin
               @(posedge CORE_CLK);
               #2;
            end
            req_read_end = 1'b1;
            @(posedge CORE_CLK);
            #2 req_read_end = 1'b0;
         end
      join
      chk(24'(nbytes >= want), 24'h000001);
      chk(24'(byte_data), 24'(fbyte(exp_addr - 24'h000001)));
   endtask
   // Flash engine: random gaps, waits on ready, ends reads on stop
   task automatic send(input logic [7:0] b);
      logic r;
      // At least one edge, so every change lands 2 ns after an edge
      repeat (int'(rnd[1:0]) + 1) @(posedge CORE_CLK);
      #2 fl_rvalid = 1'b1;
      fl_rdata = b;
      do begin
         @(negedge CORE_CLK);
         r = fl_rready;
         @(posedge CORE_CLK);
      end while (r !== 1'b1);
      #2 fl_rvalid = 1'b0;
      fl_rdata = ~b; // Released line shows no stale byte
   endtask
   initial begin : engine
      op_t op;
      logic [23:0] a;
      logic [7:0] w;
      forever begin
         @(negedge CORE_CLK);
         if (fl_start === 1'b1) begin
            op = fl_op;
            a = fl_addr;
            w = fl_wdata;
            @(posedge CORE_CLK);
            #2;
            if (op == OP_PROTECT) begin
               stat_reg = w;
            end
            if (op == OP_READ) begin
               do begin
                  send(fbyte(a));
                  a = a + 24'h000001;
               end while (fl_stop !== 1'b1);
            end else if (op == OP_SID || op == OP_RDID || op == OP_STATUS) begin
               send(op == OP_SID ? SID_VAL : (op == OP_RDID ? CAP_VAL : stat_reg));
            end else begin
               repeat (int'(rnd[1:0]) + 1) @(posedge CORE_CLK);
               #2;
            end
            fl_done = 1'b1;
            @(posedge CORE_CLK);
            #2 fl_done = 1'b0;
         end
      end
   end

   // ****************************************
   // Clock, consumer, timeout, sequence
   // ****************************************
   always #25 CORE_CLK = ~CORE_CLK;
   // Consumer stalls at random
   always @(posedge CORE_CLK) begin
      #2;
      rnd = lfsr(rnd);
      byte_ready = !stall && rnd[0];
   end
   // Taken bytes checked at the falling edge where all is settled
   always @(negedge CORE_CLK) begin
      if (byte_valid === 1'b1 && byte_ready === 1'b1) begin
         chk(byte_addr, exp_addr);
         chk(24'(byte_data), 24'(fbyte(exp_addr)));
         exp_addr = exp_addr + 24'h000001;
         nbytes++;
      end
   end
   always @(posedge CORE_CLK) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         tally_and_finish();
      end
   end
   initial begin
      logic [23:0] a;
      logic [7:0] sv;
      reset_dut();
      chk(24'(req_idle), 24'h000001);
      do_op(OP_SID, 24'h000000, 8'h00);
      chk(24'(sid), 24'(SID_VAL));
      do_op(OP_RDID, 24'h000000, 8'h00);
      chk(24'(cap), 24'(CAP_VAL));
      sv = 8'h00;
      for (int bp = 0; bp < 8; bp++) begin
         do_op(OP_PROTECT, 24'h000000, 8'(bp << 2));
         chk(24'(stat), 24'(sv));
         chk(24'(fif.status_out), 24'(sv));
         do_op(OP_STATUS, 24'h000000, 8'h00);
         sv = 8'(bp << 2);
         chk(24'(stat), 24'(sv));
         for (int j = 0; j < 2; j++) begin
            rnd = lfsr(rnd);
            a = rnd[23:0];
            if (j == 0) begin
               a[23:16] = 8'hff; // Top sector is in every protected span
            end
            do_op(OP_ERASE, a, 8'h00);
            chk(24'(erase_ref), 24'(exp_prot(a, 3'(bp))));
            do_op(OP_WRITE, a, rnd[31:24]);
            chk(24'(write_ref), 24'(exp_prot(a, 3'(bp))));
         end
      end
      do_read(24'h01fffd, 6, 1'b1);
      do_read(rnd[23:0], 3 + int'(rnd[26:24]), 1'b0);
      chk(24'(fif.silicon_ident_out), 24'(SID_VAL));
      chk(24'(fif.capacity_id_out), 24'(CAP_VAL));
      reset_dut();
      chk(24'(sid), 24'h000000);
      chk(24'(fif.silicon_ident_out), 24'h000000);
      chk(24'(byte_valid), 24'h000000);
      chk(24'(byte_data), 24'h000000);
      do_op(OP_STATUS, 24'h000000, 8'h00);
      chk(24'(stat), 24'(stat_reg));
      tally_and_finish();
   end
endmodule // tb_top
